// File: logic/eacil_defs.vh
`ifndef EACIL_DEFS_VH
`define EACIL_DEFS_VH

`define EACIL_PINCTRL    8'h00
`define EACIL_ENA        8'h04
`define EACIL_ENB        8'h08
`define EACIL_MODE       8'h0c
`define EACIL_CMD        8'h10
`define EACIL_STAT       8'h14
`define EACIL_EVT        8'h18
`define EACIL_EVMASK     8'h1c

`define EACIL_SENSE_BIT  2
`define EACIL_GATE_BIT   3
`define EACIL_EXT_EN_BIT 0
`define EACIL_CNV_EN_BIT 2
`define EACIL_CMP_BIT    3

`define EACIL_REG_RST    4'h0

`define EACIL_OP_NOP     4'h0
`define EACIL_OP_SKIPX   4'h1
`define EACIL_OP_EI      4'h2
`define EACIL_OP_DI      4'h3
`define EACIL_OP_RTI     4'h4
`define EACIL_OP_SKIPC   4'h5
`define EACIL_OP_CSTART  4'h6
`define EACIL_OP_PDARM   4'h7
`define EACIL_OP_PD      4'h8

`define EACIL_EV_EXT     0
`define EACIL_EV_CNV     1
`define EACIL_EV_DONE    2
`define EACIL_EV_PD      3

`define EACIL_CMP_MC     8
`define EACIL_CONV_MC    32
`define EACIL_MC_CLKS    1

`endif

// File: logic/eacil_sync.v
`timescale 1ns/100ps
`default_nettype none
module eacil_sync #(
    parameter W = 1
) (
    input  wire         clk,
    input  wire         rstn,
    input  wire         ce,
    input  wire [W-1:0] d,
    output reg  [W-1:0] q
);
    reg [W-1:0] meta;

    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            meta <= {W{1'b0}};
            q    <= {W{1'b0}};
        end else if (ce) begin
            meta <= d;
            q    <= meta;
        end
    end
endmodule
`default_nettype wire

// File: logic/eacil_conv.v
`timescale 1ns/100ps
`default_nettype none
`include "eacil_defs.vh"
module eacil_conv #(
    parameter CMP_MC  = `EACIL_CMP_MC,
    parameter CONV_MC = `EACIL_CONV_MC
) (
    input  wire clk,
    input  wire rstn,
    input  wire ce,
    input  wire mc_tick,
    input  wire start,
    input  wire cmp_mode,
    input  wire cmp_above,
    output reg  busy,
    output reg  done
);
    reg [7:0] left;

    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            busy <= 1'b0;
            done <= 1'b0;
            left <= 8'h00;
        end else if (ce) begin
            done <= 1'b0;
            if (start) begin
                // a restart simply reloads, the partial result is dropped
                busy <= 1'b1;
                left <= cmp_mode ? CMP_MC[7:0] : CONV_MC[7:0];
            end else if (busy && mc_tick) begin
                if (left == 8'h01) begin
                    busy <= 1'b0;
                    left <= 8'h00;
                    // comparator mode with input above reference: no completion
                    done <= ~(cmp_mode & cmp_above);
                end else begin
                    left <= left - 8'h01;
                end
            end
        end
    end
endmodule
`default_nettype wire

// File: logic/eacil_top.v
`timescale 1ns/100ps
`default_nettype none
`include "eacil_defs.vh"
module eacil_top #(
    parameter MC_CLKS = `EACIL_MC_CLKS,
    parameter CMP_MC  = `EACIL_CMP_MC,
    parameter CONV_MC = `EACIL_CONV_MC
) (
    input  wire        pclk,
    input  wire        presetn,
    input  wire        ce,
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [7:0]  paddr,
    input  wire [31:0] pwdata,
    output reg  [31:0] prdata,
    output wire        pready,
    output wire        pslverr,
    input  wire        int_pin,
    input  wire        cmp_above,
    output wire        irq,
    output reg         ext_accept,
    output reg         conv_accept,
    output reg         skip_flag,
    output wire        pin_input_en,
    output wire        ram_backup_sel,
    output reg         power_down
);
    reg  [3:0] irq_pin_control_reg;
    reg  [3:0] irq_enable_reg_a;
    reg  [3:0] irq_enable_reg_b;
    reg  [3:0] converter_mode_reg;
    reg  [3:0] evt;
    reg  [3:0] evmask;
    reg  [3:0] last_op;
    reg        external_request_flag;
    reg        conversion_complete_flag;
    reg        global_irq_enable_flag;
    reg        in_service;
    reg        ei_pending;
    reg        pd_armed;
    reg        lvl_prev;
    reg  [7:0] mc_cnt;
    reg        mc_tick;
    reg  [3:0] rd_val;
    reg  [3:0] next_evt;
    wire       pin_s;
    wire       above_s;
    wire       conv_busy;
    wire       conv_done;

    function addr_hit;
        input [7:0] a;
        begin
            addr_hit = (a[1:0] == 2'b00) && (a[7:5] == 3'b000);
        end
    endfunction

    function is_op;
        input       go;
        input [3:0] op;
        input [3:0] code;
        begin
            is_op = go && (op == code);
        end
    endfunction

    // ce low stretches the access phase so no write is lost while frozen
    assign pready  = ce;
    assign pslverr = psel & penable & ~addr_hit(paddr);

    wire wr     = psel & penable & pwrite & ce & addr_hit(paddr);
    wire op_wr  = wr && (paddr == `EACIL_CMD);
    wire [3:0] op = pwdata[3:0];

    wire op_skipx  = is_op(op_wr, op, `EACIL_OP_SKIPX);
    wire op_ei     = is_op(op_wr, op, `EACIL_OP_EI);
    wire op_di     = is_op(op_wr, op, `EACIL_OP_DI);
    wire op_rti    = is_op(op_wr, op, `EACIL_OP_RTI);
    wire op_skipc  = is_op(op_wr, op, `EACIL_OP_SKIPC);
    wire op_cstart = is_op(op_wr, op, `EACIL_OP_CSTART);
    wire op_pdarm  = is_op(op_wr, op, `EACIL_OP_PDARM);
    wire op_pd     = is_op(op_wr, op, `EACIL_OP_PD);

    eacil_sync #(
        .W (2)
    ) u_sync (
        .clk  (pclk),
        .rstn (presetn),
        .ce   (ce),
        .d    ({cmp_above, int_pin}),
        .q    ({above_s, pin_s})
    );

    // one machine cycle spans MC_CLKS bus clocks
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mc_cnt  <= 8'h00;
            mc_tick <= 1'b0;
        end else if (ce) begin
            if (mc_cnt == MC_CLKS[7:0] - 8'h01) begin
                mc_cnt  <= 8'h00;
                mc_tick <= 1'b1;
            end else begin
                mc_cnt  <= mc_cnt + 8'h01;
                mc_tick <= 1'b0;
            end
        end
    end

    eacil_conv #(
        .CMP_MC  (CMP_MC),
        .CONV_MC (CONV_MC)
    ) u_conv (
        .clk       (pclk),
        .rstn      (presetn),
        .ce        (ce),
        .mc_tick   (mc_tick),
        .start     (op_cstart),
        .cmp_mode  (converter_mode_reg[`EACIL_CMP_BIT]),
        .cmp_above (above_s),
        .busy      (conv_busy),
        .done      (conv_done)
    );

    // gate low forces the pin off and selects the backup state
    assign pin_input_en   = irq_pin_control_reg[`EACIL_GATE_BIT];
    assign ram_backup_sel = ~irq_pin_control_reg[`EACIL_GATE_BIT];

    // sense and gate feed the level itself, so rewriting either one can
    // produce an edge; software masks the source around it
    wire lvl = irq_pin_control_reg[`EACIL_GATE_BIT] &
               (irq_pin_control_reg[`EACIL_SENSE_BIT] ? pin_s : ~pin_s);
    wire ext_edge = lvl & ~lvl_prev;

    // switching comparator mode off can leave a stale completion behind
    wire mode_wr  = wr && (paddr == `EACIL_MODE);
    wire conv_spur = mode_wr & converter_mode_reg[`EACIL_CMP_BIT] &
                     ~pwdata[`EACIL_CMP_BIT] & ~above_s;

    // single level only: in_service blocks any further acceptance
    wire acc_ok   = global_irq_enable_flag & ~in_service;
    wire ext_take = acc_ok & irq_enable_reg_a[`EACIL_EXT_EN_BIT] &
                    external_request_flag;
    wire cnv_take = acc_ok & irq_enable_reg_b[`EACIL_CNV_EN_BIT] &
                    conversion_complete_flag & ~ext_take;

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            lvl_prev <= 1'b0;
        end else if (ce) begin
            lvl_prev <= lvl;
        end
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_pin_control_reg <= `EACIL_REG_RST;
            irq_enable_reg_a    <= `EACIL_REG_RST;
            irq_enable_reg_b    <= `EACIL_REG_RST;
            converter_mode_reg  <= `EACIL_REG_RST;
            evmask              <= `EACIL_REG_RST;
            last_op             <= `EACIL_OP_NOP;
        end else if (wr) begin
            case (paddr)
                `EACIL_PINCTRL: begin
                    irq_pin_control_reg <= pwdata[3:0];
                end
                `EACIL_ENA: begin
                    irq_enable_reg_a <= pwdata[3:0];
                end
                `EACIL_ENB: begin
                    irq_enable_reg_b <= pwdata[3:0];
                end
                `EACIL_MODE: begin
                    converter_mode_reg <= pwdata[3:0];
                end
                `EACIL_CMD: begin
                    last_op <= pwdata[3:0];
                end
                `EACIL_EVMASK: begin
                    evmask <= pwdata[3:0];
                end
                default: begin
                end
            endcase
        end
    end

    // request flags: a set in the clearing cycle wins
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            external_request_flag    <= 1'b0;
            conversion_complete_flag <= 1'b0;
            skip_flag                <= 1'b0;
        end else if (ce) begin
            if (ext_edge) begin
                external_request_flag <= 1'b1;
            end else if (op_skipx || ext_take) begin
                external_request_flag <= 1'b0;
            end
            if (conv_done || conv_spur) begin
                conversion_complete_flag <= 1'b1;
            end else if (op_skipc || cnv_take) begin
                conversion_complete_flag <= 1'b0;
            end
            // the skip outcome is the flag as it stood; a no-op follows it
            if (op_skipx) begin
                skip_flag <= external_request_flag;
            end else if (op_skipc) begin
                skip_flag <= conversion_complete_flag;
            end
        end
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            global_irq_enable_flag <= 1'b0;
            in_service             <= 1'b0;
            ei_pending             <= 1'b0;
            ext_accept             <= 1'b0;
            conv_accept            <= 1'b0;
        end else if (ce) begin
            ext_accept  <= ext_take;
            conv_accept <= cnv_take;
            if (ext_take || cnv_take) begin
                global_irq_enable_flag <= 1'b0;
                in_service             <= 1'b1;
            end else if (op_rti) begin
                in_service <= 1'b0;
                // enable only when the enable came just before return
                if (ei_pending) begin
                    global_irq_enable_flag <= 1'b1;
                end
            end else if (op_ei && !in_service) begin
                global_irq_enable_flag <= 1'b1;
            end else if (op_di) begin
                global_irq_enable_flag <= 1'b0;
            end
            if (op_wr) begin
                ei_pending <= op_ei & in_service;
            end
        end
    end

    // arm must be the command right before power-down; interrupts
    // are expected to be masked by then
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pd_armed   <= 1'b0;
            power_down <= 1'b0;
        end else if (ce) begin
            if (op_wr) begin
                pd_armed <= op_pdarm;
            end
            if (op_pd && pd_armed) begin
                power_down <= 1'b1;
            end else if (ext_edge) begin
                power_down <= 1'b0;
            end
        end
    end

    always @* begin
        next_evt = evt;
        if (wr && (paddr == `EACIL_EVT)) begin
            next_evt = evt & ~pwdata[3:0];
        end
        if (ext_take) begin
            next_evt[`EACIL_EV_EXT] = 1'b1;
        end
        if (cnv_take) begin
            next_evt[`EACIL_EV_CNV] = 1'b1;
        end
        if (conv_done) begin
            next_evt[`EACIL_EV_DONE] = 1'b1;
        end
        if (op_pd && pd_armed) begin
            next_evt[`EACIL_EV_PD] = 1'b1;
        end
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            evt <= `EACIL_REG_RST;
        end else if (ce) begin
            evt <= next_evt;
        end
    end

    assign irq = |(evt & evmask);

    always @* begin
        case (paddr)
            `EACIL_PINCTRL: rd_val = irq_pin_control_reg;
            `EACIL_ENA:     rd_val = irq_enable_reg_a;
            `EACIL_ENB:     rd_val = irq_enable_reg_b;
            `EACIL_MODE:    rd_val = converter_mode_reg;
            `EACIL_CMD:     rd_val = last_op;
            `EACIL_STAT:    rd_val = {in_service, global_irq_enable_flag,
                                      conversion_complete_flag,
                                      external_request_flag};
            `EACIL_EVT:     rd_val = evt;
            `EACIL_EVMASK:  rd_val = evmask;
            default:        rd_val = 4'h0;
        endcase
    end

    // read data is captured in the setup cycle so it stands for the access cycle
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
        end else if (ce && psel && !penable) begin
            prdata <= {28'h000_0000, rd_val};
        end
    end
endmodule
`default_nettype wire

// File: tb/eacil_monitor.sv
`timescale 1ns/100ps
`default_nettype none
`include "eacil_defs.vh"
module eacil_monitor (
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        ce,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] pwdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        ext_accept,
    input wire logic        conv_accept,
    input wire logic        skip_flag,
    input wire logic        pin_input_en,
    input wire logic        ram_backup_sel,
    input wire logic        power_down
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    logic       wr;
    logic       cmd_wr;
    logic       acc;
    logic       in_svc;
    logic [3:0] cur_op;
    logic [3:0] prev_op;
    assign wr = psel && penable && pwrite && ce;
    assign cmd_wr = wr && paddr == `EACIL_CMD;
    assign acc = (ext_accept || conv_accept) && ce;
    // shadow of the service state, rebuilt from accept pulses and return ops
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            in_svc <= 1'b0;
            cur_op <= 4'h0;
            prev_op <= 4'h0;
        end else begin
            if (acc)
                in_svc <= 1'b1;
            else if (cmd_wr && pwdata[3:0] == `EACIL_OP_RTI)
                in_svc <= 1'b0;
            if (cmd_wr) begin
                prev_op <= cur_op;
                cur_op <= pwdata[3:0];
            end
        end
    end
    a_pready_ce: assert property (pready == ce) else $error("pready differs from ce");
    a_slverr_unmapped: assert property (psel && penable && paddr[7:5] != 3'h0 |-> pslverr)
        else $error("no error on unmapped access");
    a_gate_write: assert property (wr && paddr == `EACIL_PINCTRL |=>
        pin_input_en == $past(pwdata[`EACIL_GATE_BIT])) else $error("pin enable not gate bit");
    a_backup_inverse: assert property (ram_backup_sel == !pin_input_en)
        else $error("backup select not inverse of pin enable");
    a_no_nesting: assert property (acc |-> !in_svc) else $error("nested accept");
    a_accept_once: assert property (acc |-> !(ext_accept && conv_accept) ##1 !acc)
        else $error("accept repeated or doubled");
    a_pd_after_arm: assert property ($rose(power_down) |->
        cur_op == `EACIL_OP_PD && prev_op == `EACIL_OP_PDARM) else $error("power-down unarmed");
    a_skip_on_op: assert property ($changed(skip_flag) |-> $past(cmd_wr &&
        (pwdata[3:0] == `EACIL_OP_SKIPX || pwdata[3:0] == `EACIL_OP_SKIPC)))
        else $error("skip flag moved without skip op");
endmodule
bind eacil_top eacil_monitor u_mon (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
    .pslverr(pslverr), .ext_accept(ext_accept), .conv_accept(conv_accept),
    .skip_flag(skip_flag), .pin_input_en(pin_input_en), .ram_backup_sel(ram_backup_sel),
    .power_down(power_down));
`default_nettype wire

// File: tb/tb_top.sv
`timescale 1ns/100ps
`default_nettype none
`include "eacil_defs.vh"
module tb_top;
    logic        pclk, presetn, ce, psel, penable, pwrite, int_pin, cmp_above, err, got;
    logic [7:0]  paddr;
    logic [31:0] pwdata, rd;
    wire  [31:0] prdata;
    wire         pready, pslverr, irq, ext_accept, conv_accept, skip_flag;
    wire         pin_input_en, ram_backup_sel, power_down;
    int          num_errors = 0;
    int          n_tests = 0;
    int          i;
    logic [7:0]  t_a [0:4] = '{`EACIL_PINCTRL, `EACIL_ENA, `EACIL_ENB, `EACIL_MODE, `EACIL_EVMASK};
    logic [31:0] t_v [0:4] = '{32'hc, 32'h1, 32'h4, 32'h8, 32'hf};
    // short conversion keeps the restart case quick
    eacil_top #(.CONV_MC(6)) dut (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .int_pin(int_pin), .cmp_above(cmp_above),
        .irq(irq), .ext_accept(ext_accept), .conv_accept(conv_accept), .skip_flag(skip_flag),
        .pin_input_en(pin_input_en), .ram_backup_sel(ram_backup_sel), .power_down(power_down));
    initial begin
        pclk = 1'b0;
        forever #12.5 pclk = ~pclk;
    end
    task check(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            num_errors++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task rdc(input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        check(rd, exp);
    endtask
    task op(input logic [3:0] c);
        apb(1'b1, `EACIL_CMD, {28'h0, c});
    endtask
    task cyc(input int n);
        repeat (n) @(posedge pclk);
    endtask
    task edge_pin;
        int_pin <= 1'b0;
        cyc(4);
        int_pin <= 1'b1;
        cyc(8);
    endtask
    task wait_acc;
        got = 1'b0;
        repeat (12) begin
            @(posedge pclk);
            if (ext_accept === 1'b1)
                got = 1'b1;
        end
    endtask
    task stop_test;
        $display("errors=%0d checks=%0d", num_errors, n_tests);
        if (num_errors == 0 && n_tests > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    initial begin
        #(25 * 5000);
        num_errors++;
        stop_test;
    end
    initial begin
        presetn = 1'b0;
        ce = 1'b1;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        int_pin = 1'b0;
        cmp_above = 1'b0;
        cyc(20);
        presetn <= 1'b1;
        check(32'({irq, pin_input_en, ram_backup_sel, power_down}), 32'h2);
        for (i = 0; i < 8; i++)
            rdc(8'(i * 4), 32'h0);
        for (i = 0; i < 5; i++) begin
            apb(1'b1, t_a[i], t_v[i]);
            rdc(t_a[i], t_v[i]);
        end
        op(`EACIL_OP_SKIPX);
        op(`EACIL_OP_NOP);
        rdc(`EACIL_STAT, 32'h0);
        op(`EACIL_OP_EI);
        int_pin <= 1'b1;
        wait_acc;
        check(32'(got), 32'h1);
        rdc(`EACIL_STAT, 32'h8);
        apb(1'b1, `EACIL_EVT, 32'h1);
        rdc(`EACIL_EVT, 32'h0);
        check(32'(irq), 32'h0);
        edge_pin;
        rdc(`EACIL_STAT, 32'h9);
        op(`EACIL_OP_EI);
        rdc(`EACIL_STAT, 32'h9);
        op(`EACIL_OP_RTI);
        wait_acc;
        check(32'(got), 32'h1);
        op(`EACIL_OP_NOP);
        op(`EACIL_OP_RTI);
        rdc(`EACIL_STAT, 32'h0);
        edge_pin;
        op(`EACIL_OP_SKIPX);
        cyc(1);
        check(32'(skip_flag), 32'h1);
        op(`EACIL_OP_SKIPX);
        cyc(1);
        check(32'(skip_flag), 32'h0);
        apb(1'b1, `EACIL_ENA, 32'h0);
        apb(1'b1, `EACIL_PINCTRL, 32'h4);
        edge_pin;
        rdc(`EACIL_STAT, 32'h0);
        apb(1'b1, `EACIL_PINCTRL, 32'hc);
        cyc(6);
        rdc(`EACIL_STAT, 32'h1);
        op(`EACIL_OP_SKIPX);
        op(`EACIL_OP_NOP);
        rdc(`EACIL_STAT, 32'h0);
        op(`EACIL_OP_CSTART);
        cyc(4);
        rdc(`EACIL_STAT, 32'h0);
        cyc(8);
        rdc(`EACIL_STAT, 32'h2);
        op(`EACIL_OP_SKIPC);
        rdc(`EACIL_STAT, 32'h0);
        cmp_above <= 1'b1;
        cyc(3);
        op(`EACIL_OP_CSTART);
        cyc(16);
        rdc(`EACIL_STAT, 32'h0);
        cmp_above <= 1'b0;
        apb(1'b1, `EACIL_ENB, 32'h0);
        cyc(3);
        apb(1'b1, `EACIL_MODE, 32'h0);
        rdc(`EACIL_STAT, 32'h2);
        op(`EACIL_OP_SKIPC);
        rdc(`EACIL_STAT, 32'h0);
        op(`EACIL_OP_CSTART);
        cyc(2);
        op(`EACIL_OP_CSTART);
        cyc(2);
        rdc(`EACIL_STAT, 32'h0);
        cyc(6);
        rdc(`EACIL_STAT, 32'h2);
        apb(1'b1, `EACIL_EVMASK, 32'h0);
        cyc(1);
        check(32'(irq), 32'h0);
        apb(1'b1, `EACIL_EVMASK, 32'h4);
        cyc(1);
        check(32'(irq), 32'h1);
        apb(1'b1, `EACIL_EVT, 32'hf);
        cyc(1);
        check(32'(irq), 32'h0);
        apb(1'b0, 8'h20, 32'h0);
        check({err, rd[30:0]}, 32'h80000000);
        op(`EACIL_OP_PD);
        cyc(1);
        check(32'(power_down), 32'h0);
        apb(1'b1, `EACIL_PINCTRL, 32'h0);
        op(`EACIL_OP_DI);
        op(`EACIL_OP_PDARM);
        op(`EACIL_OP_PD);
        cyc(1);
        check(32'(power_down), 32'h1);
        ce <= 1'b0;
        cyc(2);
        check(32'({pready, power_down}), 32'h1);
        ce <= 1'b1;
        cyc(1);
        stop_test;
    end
endmodule
`default_nettype wire
